// ### common/wdp_pkg.sv
// Constants and types for the watchdog and soft power control block
package wdp_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned SEC_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned SECS_PER_MIN = 60;
  localparam int unsigned LED_HALF_NS = 500;
  localparam int unsigned LED_HALF_CYC = LED_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned DLY_UNIT_MS = 100;
  localparam int unsigned DLY_UNIT_CYC = DLY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  // Bus decode
  localparam int unsigned AW = 32;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_UNITS = 8'hF1;
  localparam logic [7:0] IDX_TMO = 8'hF2;
  localparam logic [7:0] IDX_CFG = 8'hF3;
  localparam logic [7:0] IDX_CTRL = 8'hF4;
  localparam logic [7:0] IDX_GPA = 8'hF6;
  localparam logic [7:0] IDX_GPB = 8'hF7;
  localparam logic [7:0] IDX_GPD = 8'hF8;
  localparam logic [7:0] IDX_DLY = 8'hB8;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DLY_RST = 8'h05;
  // Field positions
  localparam int unsigned CFG_GAME = 0;
  localparam int unsigned CFG_KBD = 1;
  localparam int unsigned CFG_MOUSE = 2;
  localparam int unsigned CFG_LED = 3;
  localparam int unsigned CFG_IRQ_LSB = 4;
  localparam int unsigned CFG_IRQ_MSB = 7;
  localparam int unsigned CTRL_STATUS = 0;
  localparam int unsigned CTRL_LED = 1;
  localparam int unsigned CTRL_FORCE = 2;
  localparam int unsigned CTRL_KBC = 3;
  localparam int unsigned CTRL_STOP = 5;
  localparam int unsigned CTRL_RESTART = 6;
  localparam int unsigned CTRL_SOFT_POWER_OFF = 7;
  localparam int unsigned UNITS_SEC = 7;
  localparam int unsigned GP_EN_MSB = 1;
  // Interrupt select codes
  localparam logic [3:0] IRQ_OFF = 4'h0;
  localparam logic [3:0] IRQ_BAD = 4'h2;
  // Event line positions
  localparam int unsigned EV_GAME = 0;
  localparam int unsigned EV_KBD = 1;
  localparam int unsigned EV_MOUSE = 2;
  localparam int unsigned EV_KBC = 3;
  localparam int unsigned EV_BTN = 4;
  localparam int unsigned EV_W = 5;

  typedef struct packed {
    logic hsel;
    logic [AW-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } wdp_ahb_req_t;

  typedef struct packed {
    logic power_button;
    logic kbc_output_line;
    logic mouse_irq;
    logic kbd_irq;
    logic game_port_access;
  } wdp_evt_t;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_RUN = 2'b01,
    DLY_STOP = 2'b10
  } wdp_dly_t;

  typedef struct packed {
    logic ready;
    logic pend;
    logic p_wr;
    logic p_ok;
    logic [7:0] p_idx;
    logic [31:0] rdata;
    logic [7:0] cfg;
    logic status;
    logic led_tog;
    logic kbc_en;
    logic units_sec;
    logic [GP_EN_MSB:0] gp_en;
    logic [7:0] tmo_val;
    logic [7:0] gpa;
    logic [7:0] gpb;
    logic [7:0] gpd;
    logic [7:0] dly_val;
    logic [EV_W-1:0] sync1;
    logic [EV_W-1:0] sync2;
    logic [EV_W-1:0] prev;
    logic [31:0] pre_cnt;
    logic [5:0] sec_cnt;
    logic [7:0] elapsed;
    wdp_dly_t dly;
    logic [31:0] dly_pre;
    logic [7:0] dly_cnt;
    logic [4:0] led_cnt;
    logic led;
    logic pwr_down;
    logic [15:0] irq;
  } wdp_state_t;
endpackage : wdp_pkg

// ### core/wdp_core.sv
// Watchdog timer and soft power control with an AHB-Lite register slave
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module wdp_core #(
  parameter int unsigned SEC_CYCLES = wdp_pkg::SEC_CYC,
  parameter int unsigned DLY_CYCLES = wdp_pkg::DLY_UNIT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire wdp_pkg::wdp_ahb_req_t ahb,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Peripheral event pins
  input wire wdp_pkg::wdp_evt_t evt,
  // Outputs to the system
  output logic [15:0] irq_lines,
  output logic power_indicator_led,
  output logic power_down
);
  import wdp_pkg::*;

  wdp_state_t s;
  wdp_state_t n;
  logic [EV_W-1:0] rise;
  logic wr;
  logic wr_ctrl;
  logic [7:0] wd;
  logic [7:0] rd;
  logic accept;
  logic kick;
  logic force_to;
  logic sec_tick;
  logic unit_tick;
  logic blink;
  logic dly_tick;

  // Read mux over the current register state
  always_comb begin
    case (s.p_idx)
      IDX_UNITS: rd = {s.units_sec, 5'h00, s.gp_en};
      IDX_TMO: rd = s.tmo_val;
      IDX_CFG: rd = s.cfg;
      IDX_CTRL: rd = {2'h0, s.dly == DLY_STOP, 1'b0, s.kbc_en, 1'b0, s.led_tog,
        s.status};
      IDX_GPA: rd = s.gpa;
      IDX_GPB: rd = s.gpb;
      IDX_GPD: rd = s.gpd;
      IDX_DLY: rd = s.dly_val;
      default: rd = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    n = s;
    rise = s.sync2 & ~s.prev;
    wr = s.pend && s.p_wr && s.p_ok;
    wr_ctrl = wr && s.p_idx == IDX_CTRL;
    wd = ahb.hwdata[7:0];
    accept = ahb.hsel && ahb.htrans[1] && ahb.hready;
    n.pwr_down = 1'b0;

    // Pin synchronisers and edge memory
    n.sync1 = evt;
    n.sync2 = s.sync1;
    n.prev = s.sync2;

    // Kick sources gated by their enables
    kick = (rise[EV_GAME] && s.cfg[CFG_GAME])
      || (rise[EV_KBD] && s.cfg[CFG_KBD])
      || (rise[EV_MOUSE] && s.cfg[CFG_MOUSE]);
    // One pulse per keyboard output edge, ORed with software force
    force_to = (wr_ctrl && wd[CTRL_FORCE])
      || (rise[EV_KBC] && s.kbc_en);

    // Bus slave: one wait state, answer in the data phase
    n.ready = 1'b1;
    n.pend = 1'b0;
    if (accept) begin
      n.pend = 1'b1;
      n.ready = 1'b0;
      n.p_wr = ahb.hwrite;
      n.p_ok = ahb.haddr[AW-1:IDX_MSB+1] == '0 && ahb.haddr[IDX_LSB-1:0] == '0;
      n.p_idx = ahb.haddr[IDX_MSB:IDX_LSB];
    end
    if (s.pend) begin
      n.rdata = {24'h000000, s.p_ok ? rd : 8'h00};
    end

    // Register writes
    if (wr) begin
      case (s.p_idx)
        IDX_UNITS: begin
          n.units_sec = wd[UNITS_SEC];
          n.gp_en = wd[GP_EN_MSB:0];
        end
        IDX_TMO: n.tmo_val = wd;
        IDX_CFG: n.cfg = wd;
        IDX_CTRL: begin
          n.led_tog = wd[CTRL_LED];
          n.kbc_en = wd[CTRL_KBC];
        end
        IDX_GPA: n.gpa = wd;
        IDX_GPB: n.gpb = wd;
        IDX_GPD: n.gpd = wd;
        IDX_DLY: n.dly_val = wd;
        default: n.p_ok = s.p_ok;
      endcase
    end

    // Unit prescaler: seconds, then minutes
    sec_tick = s.pre_cnt == 32'(SEC_CYCLES - 1);
    unit_tick = sec_tick && (s.units_sec || s.sec_cnt == 6'(SECS_PER_MIN - 1));
    if (s.tmo_val == 8'h00 || s.status || kick
        || (wr && s.p_idx == IDX_TMO)) begin
      // Disabled, timed out, kicked or rewritten: clear the prescaler and elapsed count
      n.pre_cnt = 32'h00000000;
      n.sec_cnt = 6'h00;
      n.elapsed = 8'h00;
    end else begin
      n.pre_cnt = sec_tick ? 32'h00000000 : s.pre_cnt + 32'h00000001;
      if (sec_tick) begin
        n.sec_cnt = unit_tick ? 6'h00 : s.sec_cnt + 6'h01;
      end
      if (unit_tick) begin
        n.elapsed = s.elapsed + 8'h01;
      end
    end

    // Status flag: a timeout or force wins over a software clear
    if (wr_ctrl) begin
      n.status = wd[CTRL_STATUS];
    end
    if (force_to || (unit_tick && s.tmo_val != 8'h00 && !s.status && !kick
        && s.elapsed + 8'h01 == s.tmo_val)) begin
      n.status = 1'b1;
    end

    // Interrupt routing from the selected nibble
    n.irq = 16'h0000;
    if (s.status && s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] != IRQ_OFF
        && s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] != IRQ_BAD) begin
      n.irq[s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB]] = 1'b1;
    end

    // Power LED blink at 1 MHz, even duty
    blink = (s.cfg[CFG_LED] && s.status) || s.led_tog;
    if (!blink) begin
      n.led_cnt = 5'h00;
      n.led = 1'b0;
    end else if (s.led_cnt == 5'(LED_HALF_CYC - 1)) begin
      n.led_cnt = 5'h00;
      n.led = !s.led;
    end else begin
      n.led_cnt = s.led_cnt + 5'h01;
    end

    // Power-button delay
    dly_tick = s.dly_pre == 32'(DLY_CYCLES - 1);
    unique case (s.dly)
      DLY_IDLE, DLY_STOP: begin
        if (rise[EV_BTN]) begin
          n.dly = DLY_RUN;
          n.dly_pre = 32'h00000000;
          n.dly_cnt = 8'h00;
        end
      end
      DLY_RUN: begin
        n.dly_pre = dly_tick ? 32'h00000000 : s.dly_pre + 32'h00000001;
        if (dly_tick) begin
          n.dly_cnt = s.dly_cnt + 8'h01;
          if (s.dly_cnt + 8'h01 >= s.dly_val) begin
            n.dly = DLY_IDLE;
            n.pwr_down = 1'b1;
          end
        end
      end
      default: n.dly = DLY_IDLE;
    endcase
    if (wr_ctrl && wd[CTRL_STOP]) begin
      n.dly = DLY_STOP;
      n.pwr_down = 1'b0;
    end
    if (wr_ctrl && wd[CTRL_RESTART]) begin
      n.dly = DLY_RUN;
      n.dly_pre = 32'h00000000;
      n.dly_cnt = 8'h00;
      n.pwr_down = 1'b0;
    end
    if (wr_ctrl && wd[CTRL_SOFT_POWER_OFF]) begin
      n.pwr_down = 1'b1;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ready <= 1'b1;
      s.cfg <= REG_RST;
      s.dly_val <= DLY_RST;
      s.dly <= DLY_IDLE;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops
  assign hreadyout = s.ready;
  assign hrdata = s.rdata;
  assign hresp = s.pend && 1'b0;
  assign irq_lines = s.irq;
  assign power_indicator_led = s.led;
  assign power_down = s.pwr_down;

  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Kicks reload the counter
  game_kick_a: assert property ((rise[EV_GAME] && s.cfg[CFG_GAME] && !wr_ctrl)
    |=> s.elapsed == 8'h00 && s.pre_cnt == 32'h00000000)
    else $error("game port kick did not reload");
  kbd_kick_a: assert property ((rise[EV_KBD] && s.cfg[CFG_KBD])
    |=> s.elapsed == 8'h00 && s.pre_cnt == 32'h00000000)
    else $error("keyboard kick did not reload");
  mouse_kick_a: assert property ((rise[EV_MOUSE] && s.cfg[CFG_MOUSE])
    |=> s.elapsed == 8'h00 && s.pre_cnt == 32'h00000000)
    else $error("mouse kick did not reload");
  // Timeout sources set status
  force_sets_a: assert property ((wr_ctrl && wd[CTRL_FORCE]) |=> s.status)
    else $error("software force did not set status");
  kbc_force_a: assert property ((rise[EV_KBC] && s.kbc_en) |=> s.status)
    else $error("keyboard output edge did not force timeout");
  expire_sets_a: assert property ((unit_tick && !kick && !wr_ctrl && !s.status
    && s.tmo_val != 8'h00 && s.elapsed + 8'h01 == s.tmo_val) |=> s.status ##1 s.irq != 16'h0000
    || s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] == IRQ_OFF || s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] == IRQ_BAD)
    else $error("expiry did not set status");
  // Interrupt routing
  irq_three_a: assert property ((s.status && s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] == 4'h3)
    |=> s.irq == 16'h0008)
    else $error("IRQ3 routing wrong");
  irq_invalid_a: assert property ((s.cfg[CFG_IRQ_MSB:CFG_IRQ_LSB] == IRQ_BAD)
    |=> s.irq == 16'h0000)
    else $error("invalid selection drove an interrupt");
  // LED half period and off while disabled
  led_toggle_a: assert property ((blink && s.led_cnt == 5'(LED_HALF_CYC - 1))
    |=> s.led != $past(s.led))
    else $error("LED did not toggle at half period");
  led_off_a: assert property ((!s.led_tog && !s.status) |=> !s.led)
    else $error("LED blinking while disabled");
  // Delay control
  stop_reads_a: assert property ((wr_ctrl && wd[CTRL_STOP] && !wd[CTRL_RESTART])
    |=> s.dly == DLY_STOP && s.pwr_down == $past(wd[CTRL_SOFT_POWER_OFF])
    ##1 s.dly == DLY_STOP || $past(rise[EV_BTN]))
    else $error("stop did not halt the delay");
  restart_a: assert property ((wr_ctrl && wd[CTRL_RESTART])
    |=> s.dly == DLY_RUN && s.dly_cnt == 8'h00 && s.dly_pre == 32'h00000000)
    else $error("restart did not rerun the delay");
  soft_power_off_a: assert property ((wr_ctrl && wd[CTRL_SOFT_POWER_OFF]) |=> s.pwr_down)
    else $error("soft power off did not pulse");
endmodule : wdp_core

// ### tb/wdp_evt_model.sv
// Peripheral event pin model for the watchdog block
`timescale 1ns/1ps
module wdp_evt_model
  import wdp_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Event pins
  output wdp_pkg::wdp_evt_t evt
);
  initial evt = '0;

  // Drive one pin to a level just after a rising edge
  task set_pin(input int idx, input logic v);
    @(posedge hclk);
    evt[idx] <= v;
  endtask : set_pin

  // One clean pulse, high and low long enough for the synchronizer
  task pulse(input int idx);
    set_pin(idx, 1'b1);
    repeat (2) @(posedge hclk);
    evt[idx] <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : pulse
endmodule : wdp_evt_model

// ### tb/tb.sv
// Self-checking testbench for the watchdog and soft power control block
`timescale 1ns/1ps
module tb
  import wdp_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  wdp_ahb_req_t req = '0;
  wdp_ahb_req_t ahb_in;
  wdp_evt_t evt;
  logic hreadyout;
  logic hresp;
  logic power_indicator_led;
  logic power_down;
  logic [31:0] hrdata;
  logic [15:0] irq_lines;
  logic [15:0] exp_irq;
  logic led_was;
  int err_count = 0;
  int total_checks = 0;
  int pd_cnt = 0;
  int cycles = 0;
  int codes[5] = '{1, 3, 15, 0, 2};

  // The single slave's ready is the bus ready
  assign ahb_in = {req[$bits(req)-1:1], hreadyout};
  // Clock, 20 ns period
  always #10 hclk = ~hclk;

  wdp_core #(.SEC_CYCLES(20), .DLY_CYCLES(10)) wdp_core_inst (
    .hclk(hclk), .hresetn(hresetn), .ahb(ahb_in), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .evt(evt), .irq_lines(irq_lines),
    .power_indicator_led(power_indicator_led), .power_down(power_down)
  );
  wdp_evt_model wdp_evt_model_inst (.hclk(hclk), .evt(evt));

  // Count power-down pulses and cut a hang short
  always @(posedge hclk) begin
    if (power_down === 1'b1) pd_cnt <= pd_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Compare a result against its expected value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single AHB transfer, waiting on ready in both phases
  task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    req.hsel <= 1'b1;
    req.haddr <= {22'h0, idx, 2'b00};
    req.htrans <= 2'b10;
    req.hwrite <= wr;
    req.hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask : wr

  task rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    xfer(1'b0, idx, 8'h00, v);
    chk(v, {24'h0, exp});
    chk(hresp, 1'b0);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // Main sequence
  initial begin
    cyc(8);
    hresetn <= 1'b1;
    rd(IDX_CFG, 8'h00);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_DLY, DLY_RST);
    rd(8'h10, 8'h00);
    // Minute units: one minute is 60 scaled seconds
    wr(IDX_TMO, 8'h01);
    cyc(100);
    rd(IDX_CTRL, 8'h00);
    cyc(1200);
    rd(IDX_CTRL, 8'h01);
    // Second units, two seconds; each source kicked with and without its enable
    wr(IDX_UNITS, 8'h80);
    wr(IDX_TMO, 8'h02);
    for (int i = 0; i < 3; i++) begin
      for (int en = 0; en < 2; en++) begin
        wr(IDX_CFG, 8'h30 | (8'h01 << (en ? i : (i + 1) % 3)));
        wr(IDX_CTRL, 8'h00);
        repeat (4) begin
          cyc(20);
          wdp_evt_model_inst.pulse(i);
        end
        rd(IDX_CTRL, en ? 8'h00 : 8'h01);
        chk(irq_lines, en ? 16'h0000 : 16'h0008);
      end
    end
    // LED blinks while timed out with its enable set, or while the CTRL toggle bit is set
    wr(IDX_CFG, 8'h38);
    cyc(5);
    chk(power_indicator_led, 1'b0);
    cyc(50);
    led_was = power_indicator_led;
    cyc(25);
    chk(power_indicator_led ^ led_was, 1'b1);
    wr(IDX_TMO, 8'h00);
    wr(IDX_CTRL, 8'h00);
    cyc(100);
    rd(IDX_CTRL, 8'h00);
    chk(power_indicator_led, 1'b0);
    wr(IDX_CTRL, 8'h02);
    cyc(LED_HALF_CYC - 1);
    chk(power_indicator_led, 1'b0);
    cyc(1);
    chk(power_indicator_led, 1'b1);
    cyc(LED_HALF_CYC);
    chk(power_indicator_led, 1'b0);
    wr(IDX_CTRL, 8'h00);
    cyc(3);
    chk(power_indicator_led, 1'b0);
    // Software force, then interrupt routing codes 1, 3, 15, 0 and 2
    wr(IDX_CTRL, 8'h04);
    rd(IDX_CTRL, 8'h01);
    foreach (codes[k]) begin
      wr(IDX_CFG, 8'(codes[k] * 16));
      cyc(2);
      exp_irq = (codes[k] == 0 || codes[k] == 2) ? 16'h0000 : 16'h0001 << codes[k];
      chk(irq_lines, exp_irq);
    end
    // Keyboard output held high forces one timeout only
    wr(IDX_CTRL, 8'h08);
    wdp_evt_model_inst.set_pin(EV_KBC, 1'b1);
    cyc(8);
    rd(IDX_CTRL, 8'h09);
    wr(IDX_CTRL, 8'h08);
    cyc(10);
    rd(IDX_CTRL, 8'h08);
    wdp_evt_model_inst.set_pin(EV_KBC, 1'b0);
    cyc(3);
    wr(IDX_CTRL, 8'h00);
    wdp_evt_model_inst.pulse(EV_KBC);
    cyc(4);
    rd(IDX_CTRL, 8'h00);
    // Power-button delay of three units, restarted midway
    wr(IDX_DLY, 8'h03);
    wdp_evt_model_inst.pulse(EV_BTN);
    cyc(15);
    wr(IDX_CTRL, 8'h40);
    cyc(20);
    chk(pd_cnt, 0);
    cyc(20);
    chk(pd_cnt, 1);
    wr(IDX_CTRL, 8'h80);
    cyc(3);
    chk(pd_cnt, 2);
    rd(IDX_CTRL, 8'h00);
    // Stop aborts a pending shutdown
    wdp_evt_model_inst.pulse(EV_BTN);
    cyc(5);
    rd(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h20);
    rd(IDX_CTRL, 8'h20);
    cyc(50);
    chk(pd_cnt, 2);
    print_verdict();
  end
endmodule : tb
